// [dv/mssr_host.sv]
`default_nettype none
module mssr_host (
  // clock and start
  input wire logic clock_i,
  input wire logic go_i,
  // bus commands
  output logic clear_status_o = 1'h0,
  output logic wr_en_o = 1'h0,
  output logic [2:0] wr_sel_o = 3'h0,
  output logic opc_query_o = 1'h0,
  output logic opc_cmd_o = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // clear, enable event then both masks, query, command last
  always @(negedge clock_i) begin
    n = go_i ? 1 : (n > 0 && n < 6) ? n + 1 : 0;
    clear_status_o <= n == 1;
    wr_en_o <= n inside {[2:4]};
    wr_sel_o <= 3'(8 - n);
    opc_query_o <= n == 5;
    opc_cmd_o <= n == 6;
  end
endmodule // mssr_host
`default_nettype wire

// [dv/mssr_monitor.sv]
`default_nettype none
module mssr_monitor (
  input wire logic clock_i, sys_rst_i, trig_armed_i, sens0_present_i, sens1_fault_i, ops_pending_i,
  input wire logic opc_cmd_i, opc_query_i, clear_status_i, rd_en_i, rd_valid_o, reply_valid_o,
  input wire logic [2:0] rd_sel_i,
  input wire logic [15:0] rd_data_o,
  input wire logic [7:0] reply_data_o, status_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // two edges of grace after reset, so condition history never reaches into it
  logic [1:0] rh_q = '1;
  always @(posedge clock_i) rh_q <= {rh_q[0], sys_rst_i};
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i || rh_q != 2'h0);
  arm_read_a: assert property (rd_en_i && rd_sel_i == 3'h0 |=> rd_data_o[7] == $past(trig_armed_i, 2))
    else $error("arm");
  top_zero_a: assert property (rd_en_i && rd_sel_i < 3'h2 |=> rd_data_o[15:10] == 6'h00) else $error("zero");
  pres_read_a: assert property (rd_en_i && rd_sel_i == 3'h1 |=> rd_data_o[1] == $past(sens0_present_i, 2))
    else $error("pres");
  fault_read_a: assert property (rd_en_i && rd_sel_i == 3'h1 |=> rd_data_o[4] == $past(sens1_fault_i, 2))
    else $error("fault");
  query_reply_a: assert property (opc_query_i && !ops_pending_i |=> reply_valid_o && reply_data_o == 8'h31)
    else $error("reply");
  reply_wait_a: assert property (reply_valid_o |-> !$past(ops_pending_i)) else $error("early");
  opc_event_a: assert property (opc_cmd_i && !ops_pending_i ##1 rd_en_i && rd_sel_i == 3'h3 && !clear_status_i
    |=> rd_data_o[0]) else $error("opc");
  read_pulse_a: assert property (rd_valid_o == $past(rd_en_i)) else $error("pulse");
  cover property (reply_valid_o);
  cover property (status_byte_o[5]);
  cover property (status_byte_o[7]);
endmodule // mssr_monitor
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'h0, sys_rst_i = 1'h1, rd_en_i = 1'h0, ops_pending_i = 1'h0, go = 1'h0;
  logic clear_status_i, wr_en_i, opc_query_i, opc_cmd_i, rd_valid_o, reply_valid_o;
  logic [2:0] rd_sel_i = '0, wr_sel_i;
  logic [6:0] c = '0;
  logic [7:0] reply_data_o, status_byte_o;
  logic [15:0] rd_data_o, r = 16'h3776, wd = 16'hFFFF, q[$];
  int mismatches = 0, tests_run = 0;
  always #5 clock_i = ~clock_i;
  mssr_top mssr_top_inst (.*, .trig_armed_i(c[0]), .wave_trig_i(c[1]), .repetitive_sampling_done_i(c[2]),
    .sens0_present_i(c[3]), .sens1_present_i(c[4]), .sens0_fault_i(c[5]), .sens1_fault_i(c[6]), .wr_data_i(wd));
  mssr_host mssr_host_inst (.clock_i, .go_i(go), .clear_status_o(clear_status_i), .wr_en_o(wr_en_i),
    .wr_sel_o(wr_sel_i), .opc_query_o(opc_query_i), .opc_cmd_o(opc_cmd_i));
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(logic [2:0] s, logic [15:0] e);
    @(negedge clock_i);
    rd_en_i = 1'h1;
    rd_sel_i = s;
    q.push_back(e);
    @(negedge clock_i);
    rd_en_i = 1'h0;
  endtask
  task automatic final_report;
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // answers never overlap, so one queue serves both channels
  always @(negedge clock_i) begin
    if (rd_valid_o === 1'h1) chk("rd_data_o", rd_data_o, q.pop_front());
    if (reply_valid_o === 1'h1) chk("reply_data_o", {8'h00, reply_data_o}, q.pop_front());
  end
  initial begin
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'h0;
    ops_pending_i = 1'h1;
    repeat (2) begin
      go <= 1'h1;
      q.push_back(16'h0031);
      @(negedge clock_i);
      go <= 1'h0;
      repeat (5) @(negedge clock_i);
      ops_pending_i = 1'h0;
      rd(3'h2, 16'h0020);
      rd(3'h3, 16'h0001);
      // second pass masks out measurement bit 8 and all device bits but sensor two presence
      wd = 16'hA285;
    end
    rd(3'h4, 16'h2285);
    rd(3'h7, 16'h0000);
    repeat (8) begin
      r = lfsr(r);
      c = r[6:0];
      repeat (3) @(negedge clock_i);
      rd(3'h0, {6'h00, r[2:0], 7'h00});
      rd(3'h1, {11'h000, r[6:3], 1'h0});
      repeat (2) rd(3'h2, {8'h00, |(r[2:0] & 3'h5), 5'h00, r[4], 1'h0});
      chk("status_byte_o", {8'h00, status_byte_o}, {8'h00, |(r[2:0] & 3'h5), 5'h00, r[4], 1'h0});
    end
    for (int i = 0; i < 50 && q.size() > 0; i++) @(negedge clock_i);
    chk("queue", 16'(q.size()), 16'h0000);
    final_report();
  end
endmodule // tb_top
bind mssr_top mssr_monitor mssr_monitor_inst (.*);
`default_nettype wire

// [hw/mssr_consts.vh]
`ifndef MSSR_CONSTS_VH
`define MSSR_CONSTS_VH
// register selects on the status read port
`define MSSR_SEL_MEAS 3'h0
`define MSSR_SEL_DEV 3'h1
`define MSSR_SEL_STB 3'h2
`define MSSR_SEL_ESR 3'h3
`define MSSR_SEL_MEAS_EN 3'h4
`define MSSR_SEL_DEV_EN 3'h5
`define MSSR_SEL_ESE 3'h6
// measurement-process condition bits
`define MSSR_MEAS_ARMED 7
`define MSSR_MEAS_TRIG 8
`define MSSR_MEAS_RSDONE 9
// device condition bits
`define MSSR_DEV_PRES0 1
`define MSSR_DEV_PRES1 2
`define MSSR_DEV_FAULT0 3
`define MSSR_DEV_FAULT1 4
// status byte and standard event bits
`define MSSR_STB_DEV 1
`define MSSR_STB_ESB 5
`define MSSR_STB_MEAS 7
`define MSSR_ESR_OPC 0
// reset values and reply character
`define MSSR_RST_16 16'h0000
`define MSSR_RST_8 8'h00
`define MSSR_ASCII_ONE 8'h31
`endif

// [hw/mssr_top.v]
// Functional notes
// - unused condition bits and bit 15 read zero
// - measurement bit 7 follows trigger armed
// - measurement bit 8 follows waveform trigger
// - measurement bit 9 follows repetitive sampling done
// - device bit 1 follows channel one presence
// - device bit 2 follows channel two presence
// - device bit 3 follows channel one fault
// - device bit 4 follows channel two fault
// - completion query queues ASCII one when idle
// - completion command sets event bit 0 when idle
// - status byte read is non-destructive
// - status byte bit 7 summarises enabled measurement
// - status byte bit 1 summarises enabled device
`include "mssr_consts.vh"
`default_nettype none

module mssr_top #(
  // condition and mask width
  parameter COND_W = 16,
  // status byte, event and reply width
  parameter BYTE_W = 8
) (
  // clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // measurement process conditions
  input wire trig_armed_i,
  input wire wave_trig_i,
  input wire repetitive_sampling_done_i,
  // sensor channel conditions
  input wire sens0_present_i,
  input wire sens1_present_i,
  input wire sens0_fault_i,
  input wire sens1_fault_i,
  // completion requests from the parser
  input wire ops_pending_i,
  input wire opc_cmd_i,
  input wire opc_query_i,
  input wire clear_status_i,
  // mask writes
  input wire wr_en_i,
  input wire [2:0] wr_sel_i,
  input wire [COND_W-1:0] wr_data_i,
  // register reads
  input wire rd_en_i,
  input wire [2:0] rd_sel_i,
  // read data
  output reg [COND_W-1:0] rd_data_o,
  output reg rd_valid_o,
  // completion reply
  output reg [BYTE_W-1:0] reply_data_o,
  output reg reply_valid_o,
  // live status byte
  output reg [BYTE_W-1:0] status_byte_o
);

  // zero fill above the byte-wide registers on the read port
  localparam PAD_W = COND_W - BYTE_W;

  // condition registers
  reg [COND_W-1:0] meas_cond_q;
  reg [COND_W-1:0] meas_cond_d;
  reg [COND_W-1:0] dev_cond_q;
  reg [COND_W-1:0] dev_cond_d;
  // enable masks
  reg [COND_W-1:0] meas_en_q;
  reg [COND_W-1:0] meas_en_d;
  reg [COND_W-1:0] dev_en_q;
  reg [COND_W-1:0] dev_en_d;
  reg [BYTE_W-1:0] ese_q;
  reg [BYTE_W-1:0] ese_d;
  // event register and completion tracking
  reg [BYTE_W-1:0] esr_q;
  reg [BYTE_W-1:0] esr_d;
  reg opc_arm_q;
  reg opc_arm_d;
  reg opcq_arm_q;
  reg opcq_arm_d;
  // next values of the outputs
  reg [COND_W-1:0] rd_mux_d;
  reg [COND_W-1:0] rd_data_d;
  reg rd_valid_d;
  reg [BYTE_W-1:0] reply_data_d;
  reg reply_valid_d;
  reg [BYTE_W-1:0] stb_d;
  // decoded strobes
  wire done_now;
  wire opc_fire;
  wire opcq_fire;
  wire esr_read;
  wire esr_clear;
  wire meas_en_wr;
  wire dev_en_wr;
  wire ese_wr;

  // a request taken while idle completes on the same edge
  assign done_now = ~ops_pending_i;
  assign opc_fire = (opc_arm_q | opc_cmd_i) & done_now;
  assign opcq_fire = (opcq_arm_q | opc_query_i) & done_now;
  // only the event register is read-destructive
  assign esr_read = rd_en_i & (rd_sel_i == `MSSR_SEL_ESR);
  assign esr_clear = clear_status_i | esr_read;
  assign meas_en_wr = wr_en_i & (wr_sel_i == `MSSR_SEL_MEAS_EN);
  assign dev_en_wr = wr_en_i & (wr_sel_i == `MSSR_SEL_DEV_EN);
  assign ese_wr = wr_en_i & (wr_sel_i == `MSSR_SEL_ESE);

  // conditions are levels, so sampling once per clock is enough
  always @* begin
    meas_cond_d = `MSSR_RST_16;
    meas_cond_d[`MSSR_MEAS_ARMED] = trig_armed_i;
    meas_cond_d[`MSSR_MEAS_TRIG] = wave_trig_i;
    meas_cond_d[`MSSR_MEAS_RSDONE] = repetitive_sampling_done_i;
  end

  always @* begin
    dev_cond_d = `MSSR_RST_16;
    dev_cond_d[`MSSR_DEV_PRES0] = sens0_present_i;
    dev_cond_d[`MSSR_DEV_PRES1] = sens1_present_i;
    dev_cond_d[`MSSR_DEV_FAULT0] = sens0_fault_i;
    dev_cond_d[`MSSR_DEV_FAULT1] = sens1_fault_i;
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      meas_cond_q <= `MSSR_RST_16;
    end else begin
      meas_cond_q <= meas_cond_d;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      dev_cond_q <= `MSSR_RST_16;
    end else begin
      dev_cond_q <= dev_cond_d;
    end
  end

  // bit 15 of a mask is held at zero, like the condition bit it gates
  always @* begin
    meas_en_d = meas_en_q;
    if (meas_en_wr) begin
      meas_en_d = {1'h0, wr_data_i[COND_W-2:0]};
    end
  end

  always @* begin
    dev_en_d = dev_en_q;
    if (dev_en_wr) begin
      dev_en_d = {1'h0, wr_data_i[COND_W-2:0]};
    end
  end

  always @* begin
    ese_d = ese_q;
    if (ese_wr) begin
      ese_d = wr_data_i[BYTE_W-1:0];
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      meas_en_q <= `MSSR_RST_16;
      dev_en_q <= `MSSR_RST_16;
      ese_q <= `MSSR_RST_8;
    end else begin
      meas_en_q <= meas_en_d;
      dev_en_q <= dev_en_d;
      ese_q <= ese_d;
    end
  end

  // repeated requests while one is armed merge into a single completion
  always @* begin
    opc_arm_d = opc_arm_q;
    if (opc_fire) begin
      opc_arm_d = 1'h0;
    end else if (opc_cmd_i) begin
      opc_arm_d = 1'h1;
    end
  end

  always @* begin
    opcq_arm_d = opcq_arm_q;
    if (opcq_fire) begin
      opcq_arm_d = 1'h0;
    end else if (opc_query_i) begin
      opcq_arm_d = 1'h1;
    end
  end

  // clear status empties the event register but leaves a pending request armed
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      opc_arm_q <= 1'h0;
    end else begin
      opc_arm_q <= opc_arm_d;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      opcq_arm_q <= 1'h0;
    end else begin
      opcq_arm_q <= opcq_arm_d;
    end
  end

  // a completion on the clearing edge wins, so it is never lost to a read
  always @* begin
    esr_d = esr_q;
    if (esr_clear) begin
      esr_d = `MSSR_RST_8;
    end
    if (opc_fire) begin
      esr_d[`MSSR_ESR_OPC] = 1'h1;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      esr_q <= `MSSR_RST_8;
    end else begin
      esr_q <= esr_d;
    end
  end

  // the reply is a one-cycle pulse; the character stays until the next reply
  always @* begin
    reply_valid_d = 1'h0;
    reply_data_d = reply_data_o;
    if (opcq_fire) begin
      reply_valid_d = 1'h1;
      reply_data_d = `MSSR_ASCII_ONE;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      reply_valid_o <= 1'h0;
    end else begin
      reply_valid_o <= reply_valid_d;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      reply_data_o <= `MSSR_RST_8;
    end else begin
      reply_data_o <= reply_data_d;
    end
  end

  // summaries of the masked groups; the service request bit is not kept here
  always @* begin
    stb_d = `MSSR_RST_8;
    stb_d[`MSSR_STB_MEAS] = |(meas_cond_q & meas_en_q);
    stb_d[`MSSR_STB_DEV] = |(dev_cond_q & dev_en_q);
    stb_d[`MSSR_STB_ESB] = |(esr_q & ese_q);
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      status_byte_o <= `MSSR_RST_8;
    end else begin
      status_byte_o <= stb_d;
    end
  end

  // reads are pure muxes: nothing but the event register changes on a read
  always @* begin
    case (rd_sel_i)
      `MSSR_SEL_MEAS: rd_mux_d = meas_cond_q;
      `MSSR_SEL_DEV: rd_mux_d = dev_cond_q;
      `MSSR_SEL_STB: rd_mux_d = {{PAD_W{1'h0}}, stb_d};
      `MSSR_SEL_ESR: rd_mux_d = {{PAD_W{1'h0}}, esr_q};
      `MSSR_SEL_MEAS_EN: rd_mux_d = meas_en_q;
      `MSSR_SEL_DEV_EN: rd_mux_d = dev_en_q;
      `MSSR_SEL_ESE: rd_mux_d = {{PAD_W{1'h0}}, ese_q};
      default: rd_mux_d = `MSSR_RST_16;
    endcase
  end

  // read data holds until the next read, so a slow host can still take it
  always @* begin
    rd_valid_d = rd_en_i;
    rd_data_d = rd_data_o;
    if (rd_en_i) begin
      rd_data_d = rd_mux_d;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd_valid_o <= 1'h0;
    end else begin
      rd_valid_o <= rd_valid_d;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd_data_o <= `MSSR_RST_16;
    end else begin
      rd_data_o <= rd_data_d;
    end
  end

endmodule // mssr_top

`default_nettype wire
